// ==== logic/torque_boost_map.svh ====
`ifndef TORQUE_BOOST_MAP_SVH
`define TORQUE_BOOST_MAP_SVH

// Parameter addresses on the register port.
`define ADDR_PRIMARY_BOOST   10'h000
`define ADDR_SECOND_BOOST    10'h02e
`define ADDR_APPLIED_MOTOR   10'h047
`define ADDR_MOTOR_CAPACITY  10'h050
`define ADDR_MOTOR_POLES     10'h051
`define ADDR_SPEED_GAIN      10'h059
`define ADDR_USER_GROUP      10'h0a0
`define ADDR_TERM_FIRST      10'h0b2
`define ADDR_TERM_LAST       10'h0b8
`define ADDR_CTRL_METHOD     10'h320
`define ADDR_STATUS          10'h3f0
`define ADDR_FAULT_CLEAR     10'h3f1

// Parameter encodings; boost in 0.1 %, capacity in 0.01 kW.
`define PARAM_DISABLED       16'h270f
`define BOOST_MAX            16'h012c
`define BOOST_CT_FROM        16'h001e
`define BOOST_CT_TO          16'h0014
`define CAPACITY_MIN         16'h000a
`define CAPACITY_MAX         16'h05dc
`define GAIN_MAX             16'h00c8
`define GAIN_MOTOR_MATCHED   8'h64
`define CTRL_ADVANCED        16'h0014
`define CTRL_GENERAL         16'h001e
`define FUNC_SECOND          16'h0003

// Reset values.
`define RST_PRIMARY_BOOST    16'h001e
`define RST_SECOND_BOOST     16'h270f
`define RST_APPLIED_MOTOR    16'h0000
`define RST_MOTOR_CAPACITY   16'h270f
`define RST_MOTOR_POLES      16'h270f
`define RST_SPEED_GAIN       16'h270f
`define RST_CTRL_METHOD      16'h0014
`define RST_USER_GROUP       16'h0000
`define RST_TERM_FUNC        16'h0000

// Status and fault clear bit positions.
`define STAT_MODE_LSB        0
`define STAT_SECOND          2
`define STAT_OC_ALARM        3
`define STAT_ACCEL_TRIP      4
`define STAT_MOTOR_OL        5
`define STAT_DRIVE_OL        6
`define STAT_REJECT          7

// Current thresholds in percent of rated current.
`define CUR_OC_LIMIT         10'h096
`define CUR_MOTOR_OL         10'h064
`define CUR_DRIVE_OL         10'h078

// Timing.
`define CLK_PERIOD_NS        10
`define OC_TRIP_NS           20000
`define MOTOR_OL_NS          30000
`define DRIVE_OL_NS          20000
`define OC_TRIP_CYCLES  ((`OC_TRIP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MOTOR_OL_CYCLES ((`MOTOR_OL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DRIVE_OL_CYCLES ((`DRIVE_OL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// Voltage and frequency scaling.
`define FULL_SCALE_V         11'h3e8
`define FRAC_ONE             11'h400
`define TERM_COUNT           7

`endif

// ==== logic/torque_boost_pkg.sv ====
package torque_boost_pkg;

  typedef enum logic [1:0] {
    mode_vf,
    mode_advanced,
    mode_general
  } control_mode_t;

  typedef enum logic [1:0] {
    oc_idle,
    oc_alarm,
    oc_trip
  } oc_state_t;

endpackage

// ==== logic/pin_sync.sv ====
`timescale 1ns/100ps

module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_clk_en,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta   <= '0;
      o_sync <= '0;
    end else if (i_clk_en) begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end

endmodule

// ==== logic/vf_curve.sv ====
`timescale 1ns/100ps
`include "torque_boost_map.svh"

module vf_curve (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_clk_en,
  input  wire logic [10:0] i_boost,
  input  wire logic [10:0] i_freq_frac,
  input  wire logic [10:0] i_comp,
  output logic      [10:0] o_voltage
);

  // The line runs from the boost level at 0 Hz to full voltage at the operating point.
  wire [10:0] clamped_frac = (i_freq_frac > `FRAC_ONE) ? `FRAC_ONE : i_freq_frac;
  wire [10:0] span         = `FULL_SCALE_V - i_boost;
  wire [21:0] product      = span * clamped_frac;
  wire [12:0] sum          = {2'b00, i_boost} + {2'b00, product[20:10]} + {2'b00, i_comp};
  wire [10:0] next_voltage = (sum > {2'b00, `FULL_SCALE_V}) ? `FULL_SCALE_V : sum[10:0];

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_voltage <= 11'h000;
    end else if (i_clk_en) begin
      o_voltage <= next_voltage;
    end
  end

endmodule

// ==== logic/torque_boost_control_select.sv ====
`timescale 1ns/100ps
`include "torque_boost_map.svh"

// Summary of operation
// RULE1 - The primary boost sets the 0 Hz output voltage as 0 to 30 percent of full voltage.
// RULE2 - Output voltage rises linearly with frequency from the boost level to the operating point.
// RULE3 - The second boost (0 to 30 percent, 9999 meaning none) applies while second function is on.
// RULE4 - Second function comes from any input terminal whose function parameter holds 3.
// RULE5 - Second function on also enables every other second parameter set (the code switches only the second boost and reports the signal).
// RULE6 - Both boost values act only under V/F control and are ignored under flux vector control.
// RULE7 - A primary boost of 3 percent becomes 2 percent when a constant-torque motor is selected.
// RULE8 - The applied motor code takes only the listed codes and starts at 0.
// RULE9 - Motor capacity takes 0.1 to 15 kW or 9999, its initial value, which forces V/F control.
// RULE10 - Pole count takes 2, 4, 6, 8, 10 or 9999, its initial value, which forces V/F control.
// RULE11 - Speed gain scales slip response 0 to 200 percent, 9999 using the motor-matched gain.
// RULE12 - Control method takes 20 (advanced, initial) or 30 (general) and needs both motor values.
// RULE13 - These parameters are writable only while the user group read selection is zero.
// RULE14 - Advanced flux vector control compensates voltage by load current and slips frequency.
// RULE15 - Software should step the boost by about half a percent and keep it near ten percent.
// RULE16 - Excess current gives an alarm then an acceleration trip; overload gives overload trips.
// RULE17 - Capacity or pole count at 9999 forces V/F control whatever the method setting.
module torque_boost_control_select
  import torque_boost_pkg::*;
(
  input  wire logic          i_sys_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_clk_en,
  input  wire logic [9:0]    i_addr,
  input  wire logic [15:0]   i_wdata,
  input  wire logic          i_wr,
  input  wire logic          i_rd,
  output logic      [15:0]   o_rdata,
  input  wire logic [6:0]    i_terminal,
  input  wire logic          i_accel,
  input  wire logic [10:0]   i_freq_frac,
  input  wire logic [9:0]    i_motor_current,
  output logic      [10:0]   o_voltage_pct,
  output logic      [10:0]   o_freq_out,
  output control_mode_t      o_control_mode,
  output logic               o_second_func_active,
  output logic      [7:0]    o_speed_gain_pct,
  output logic               o_overcurrent_alarm,
  output logic               o_accel_overcurrent_trip,
  output logic               o_motor_overload_trip,
  output logic               o_drive_overload_trip
);

  logic [15:0] primary_boost_pct;
  logic [15:0] second_boost_pct;
  logic [15:0] applied_motor_code;
  logic [15:0] motor_capacity_kw;
  logic [15:0] motor_pole_count;
  logic [15:0] speed_loop_gain_pct;
  logic [15:0] control_method_code;
  logic [15:0] user_group_read_sel;
  logic [15:0] input_terminal_func [`TERM_COUNT];
  logic        write_rejected;
  logic [6:0]  terminal_sync;
  oc_state_t   oc_state;
  oc_state_t   next_oc_state;
  logic [11:0] oc_count;
  logic [11:0] motor_ol_count;
  logic [11:0] drive_ol_count;

  function automatic logic motor_code_valid(input logic [15:0] code);
    case (code)
      16'h0000, 16'h0001, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
      16'h000d, 16'h000e, 16'h000f, 16'h0010, 16'h0017, 16'h0018,
      16'h0028, 16'h002b, 16'h002c, 16'h0032, 16'h0035, 16'h0036: motor_code_valid = 1'b1;
      default: motor_code_valid = 1'b0;
    endcase
  endfunction

  function automatic logic motor_code_const_torque(input logic [15:0] code);
    case (code)
      16'h0001, 16'h000d, 16'h0017, 16'h002b, 16'h0035: motor_code_const_torque = 1'b1;
      default: motor_code_const_torque = 1'b0;
    endcase
  endfunction

  pin_sync #(
    .WIDTH (7)
  ) u_terminal_sync (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_clk_en  (i_clk_en),
    .i_async   (i_terminal),
    .o_sync    (terminal_sync)
  );

  // Address decode.
  wire sel_primary  = (i_addr == `ADDR_PRIMARY_BOOST);
  wire sel_second   = (i_addr == `ADDR_SECOND_BOOST);
  wire sel_motor    = (i_addr == `ADDR_APPLIED_MOTOR);
  wire sel_capacity = (i_addr == `ADDR_MOTOR_CAPACITY);
  wire sel_poles    = (i_addr == `ADDR_MOTOR_POLES);
  wire sel_gain     = (i_addr == `ADDR_SPEED_GAIN);
  wire sel_method   = (i_addr == `ADDR_CTRL_METHOD);
  wire sel_group    = (i_addr == `ADDR_USER_GROUP);
  wire sel_term     = (i_addr >= `ADDR_TERM_FIRST) && (i_addr <= `ADDR_TERM_LAST);
  wire sel_status   = (i_addr == `ADDR_STATUS);
  wire sel_clear    = (i_addr == `ADDR_FAULT_CLEAR);
  wire [9:0] term_offset = i_addr - `ADDR_TERM_FIRST;
  wire [2:0] term_index  = term_offset[2:0];

  // Value checks per parameter.
  wire boost_ok    = (i_wdata <= `BOOST_MAX); // see RULE1
  wire second_ok   = (i_wdata <= `BOOST_MAX) || (i_wdata == `PARAM_DISABLED); // see RULE3
  wire motor_ok    = motor_code_valid(i_wdata); // see RULE8
  wire capacity_ok = ((i_wdata >= `CAPACITY_MIN) && (i_wdata <= `CAPACITY_MAX))
                     || (i_wdata == `PARAM_DISABLED); // see RULE9
  wire poles_ok    = ((i_wdata >= 16'h0002) && (i_wdata <= 16'h000a) && !i_wdata[0])
                     || (i_wdata == `PARAM_DISABLED); // see RULE10
  wire gain_ok     = (i_wdata <= `GAIN_MAX) || (i_wdata == `PARAM_DISABLED); // see RULE11
  wire method_ok   = (i_wdata == `CTRL_ADVANCED) || (i_wdata == `CTRL_GENERAL); // see RULE12

  // Parameters lock while the user group selection is nonzero; the selection itself never locks.
  wire params_open = (user_group_read_sel == 16'h0000); // see RULE13
  wire wr_en       = i_wr && i_clk_en;
  wire wr_param    = wr_en && params_open;
  wire wr_primary  = wr_param && sel_primary && boost_ok;
  wire wr_second   = wr_param && sel_second && second_ok;
  wire wr_motor    = wr_param && sel_motor && motor_ok;
  wire wr_capacity = wr_param && sel_capacity && capacity_ok;
  wire wr_poles    = wr_param && sel_poles && poles_ok;
  wire wr_gain     = wr_param && sel_gain && gain_ok;
  wire wr_method   = wr_param && sel_method && method_ok;
  wire wr_term     = wr_param && sel_term;
  wire param_hit   = sel_primary || sel_second || sel_motor || sel_capacity || sel_poles
                     || sel_gain || sel_method || sel_term;
  wire accepted    = wr_primary || wr_second || wr_motor || wr_capacity || wr_poles
                     || wr_gain || wr_method || wr_term;
  wire reject_now  = wr_en && param_hit && !accepted;
  wire wr_clear    = wr_en && sel_clear;

  // Selecting a constant-torque motor drops a primary boost of 3 % to 2 %.
  wire ct_rewrite  = wr_motor && motor_code_const_torque(i_wdata)
                     && (primary_boost_pct == `BOOST_CT_FROM); // see RULE7

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      primary_boost_pct   <= `RST_PRIMARY_BOOST;
      second_boost_pct    <= `RST_SECOND_BOOST;
      applied_motor_code  <= `RST_APPLIED_MOTOR;
      motor_capacity_kw   <= `RST_MOTOR_CAPACITY;
      motor_pole_count    <= `RST_MOTOR_POLES;
      speed_loop_gain_pct <= `RST_SPEED_GAIN;
      control_method_code <= `RST_CTRL_METHOD;
      user_group_read_sel <= `RST_USER_GROUP;
    end else begin
      if (wr_primary) begin
        primary_boost_pct <= i_wdata;
      end else if (ct_rewrite) begin
        primary_boost_pct <= `BOOST_CT_TO; // see RULE7
      end
      if (wr_second) begin
        second_boost_pct <= i_wdata;
      end
      if (wr_motor) begin
        applied_motor_code <= i_wdata;
      end
      if (wr_capacity) begin
        motor_capacity_kw <= i_wdata;
      end
      if (wr_poles) begin
        motor_pole_count <= i_wdata;
      end
      if (wr_gain) begin
        speed_loop_gain_pct <= i_wdata;
      end
      if (wr_method) begin
        control_method_code <= i_wdata;
      end
      if (wr_en && sel_group) begin
        user_group_read_sel <= i_wdata;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int t = 0; t < `TERM_COUNT; t++) begin
        input_terminal_func[t] <= `RST_TERM_FUNC;
      end
    end else if (wr_term) begin
      input_terminal_func[term_index] <= i_wdata;
    end
  end

  // A new rejection in the same cycle as the clear keeps the flag set.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      write_rejected <= 1'b0;
    end else if (i_clk_en) begin
      write_rejected <= reject_now || (write_rejected && !(wr_clear && i_wdata[`STAT_REJECT]));
    end
  end

  // Any terminal assigned the second function drives it.
  logic [6:0] term_second;
  always_comb begin
    for (int t = 0; t < `TERM_COUNT; t++) begin
      term_second[t] = terminal_sync[t] && (input_terminal_func[t] == `FUNC_SECOND); // see RULE4
    end
  end
  wire second_active = |term_second;

  // Control method resolution.
  wire motor_known = (motor_capacity_kw != `PARAM_DISABLED)
                     && (motor_pole_count != `PARAM_DISABLED); // see RULE17
  control_mode_t next_mode;
  assign next_mode = !motor_known ? mode_vf :
                     (control_method_code == `CTRL_GENERAL) ? mode_general :
                     mode_advanced; // see RULE12

  // Boost selection; the second set needs both the signal and a value other than 9999.
  wire use_second  = second_active && (second_boost_pct != `PARAM_DISABLED); // see RULE3
  wire [15:0] boost_sel = use_second ? second_boost_pct : primary_boost_pct;
  wire [10:0] boost_eff = (next_mode == mode_vf) ? boost_sel[10:0] : 11'h000; // see RULE6

  // Gain of 9999 falls back to the motor-matched value.
  wire [7:0] gain_eff = (speed_loop_gain_pct == `PARAM_DISABLED) ?
                        `GAIN_MOTOR_MATCHED : speed_loop_gain_pct[7:0]; // see RULE11

  // Load compensation: voltage lifts with current outside V/F, slip compensation only when advanced.
  wire [10:0] volt_comp = (next_mode == mode_vf) ? 11'h000 : {4'h0, i_motor_current[9:3]}; // see RULE14
  wire [17:0] slip_prod = i_motor_current * gain_eff;
  wire [11:0] slip_sum  = {1'b0, i_freq_frac} + {4'h0, slip_prod[17:10]};
  wire [10:0] next_freq = (next_mode != mode_advanced) ? i_freq_frac :
                          slip_sum[11] ? 11'h7ff : slip_sum[10:0]; // see RULE14

  vf_curve u_vf_curve (
    .i_sys_clk   (i_sys_clk),
    .i_rst_n     (i_rst_n),
    .i_clk_en    (i_clk_en),
    .i_boost     (boost_eff),
    .i_freq_frac (i_freq_frac),
    .i_comp      (volt_comp),
    .o_voltage   (o_voltage_pct)
  ); // see RULE2

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_control_mode       <= mode_vf;
      o_second_func_active <= 1'b0;
      o_speed_gain_pct     <= 8'h00;
      o_freq_out           <= 11'h000;
    end else if (i_clk_en) begin
      o_control_mode       <= next_mode;
      o_second_func_active <= second_active; // see RULE5
      o_speed_gain_pct     <= (next_mode == mode_advanced) ? gain_eff : 8'h00;
      o_freq_out           <= next_freq;
    end
  end

  // Overcurrent: alarm at once, trip if it persists during acceleration.
  wire over_current = (i_motor_current > `CUR_OC_LIMIT);
  wire oc_expired   = (oc_count == 12'(`OC_TRIP_CYCLES - 1));
  wire clr_accel    = wr_clear && i_wdata[`STAT_ACCEL_TRIP];

  always_comb begin
    next_oc_state = oc_state;
    case (oc_state)
      oc_idle: begin
        if (over_current) begin
          next_oc_state = oc_alarm; // see RULE16
        end
      end
      oc_alarm: begin
        if (!over_current) begin
          next_oc_state = oc_idle;
        end else if (i_accel && oc_expired) begin
          next_oc_state = oc_trip; // see RULE16
        end
      end
      oc_trip: begin
        if (clr_accel) begin
          next_oc_state = oc_idle;
        end
      end
      default: next_oc_state = oc_idle;
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      oc_state <= oc_idle;
      oc_count <= 12'h000;
    end else if (i_clk_en) begin
      oc_state <= next_oc_state;
      oc_count <= (oc_state == oc_alarm && i_accel && !oc_expired) ? oc_count + 12'h001 : 12'h000;
    end
  end

  // Overload timers run while current stays above each rating; trips latch until cleared.
  wire motor_ol_hit = (i_motor_current > `CUR_MOTOR_OL)
                      && (motor_ol_count == 12'(`MOTOR_OL_CYCLES - 1));
  wire drive_ol_hit = (i_motor_current > `CUR_DRIVE_OL)
                      && (drive_ol_count == 12'(`DRIVE_OL_CYCLES - 1));

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      motor_ol_count <= 12'h000;
      drive_ol_count <= 12'h000;
    end else if (i_clk_en) begin
      motor_ol_count <= (i_motor_current > `CUR_MOTOR_OL && !motor_ol_hit) ?
                        motor_ol_count + 12'h001 : 12'h000;
      drive_ol_count <= (i_motor_current > `CUR_DRIVE_OL && !drive_ol_hit) ?
                        drive_ol_count + 12'h001 : 12'h000;
    end
  end

  // A trip arriving with its clear stays set.
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_overcurrent_alarm      <= 1'b0;
      o_accel_overcurrent_trip <= 1'b0;
      o_motor_overload_trip    <= 1'b0;
      o_drive_overload_trip    <= 1'b0;
    end else if (i_clk_en) begin
      o_overcurrent_alarm      <= (next_oc_state == oc_alarm); // see RULE16
      o_accel_overcurrent_trip <= (next_oc_state == oc_trip); // see RULE16
      o_motor_overload_trip    <= motor_ol_hit
                                  || (o_motor_overload_trip && !(wr_clear && i_wdata[`STAT_MOTOR_OL]));
      o_drive_overload_trip    <= drive_ol_hit
                                  || (o_drive_overload_trip && !(wr_clear && i_wdata[`STAT_DRIVE_OL]));
    end
  end

  // Read path.
  wire [15:0] status_word = {8'h00, write_rejected, o_drive_overload_trip, o_motor_overload_trip,
                             o_accel_overcurrent_trip, o_overcurrent_alarm, o_second_func_active,
                             o_control_mode};
  wire [15:0] read_mux = sel_primary  ? primary_boost_pct :
                         sel_second   ? second_boost_pct :
                         sel_motor    ? applied_motor_code :
                         sel_capacity ? motor_capacity_kw :
                         sel_poles    ? motor_pole_count :
                         sel_gain     ? speed_loop_gain_pct :
                         sel_method   ? control_method_code :
                         sel_group    ? user_group_read_sel :
                         sel_term     ? input_terminal_func[term_index] :
                         sel_status   ? status_word :
                         16'h0000;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 16'h0000;
    end else if (i_clk_en) begin
      o_rdata <= i_rd ? read_mux : 16'h0000;
    end
  end

endmodule

// ==== testbench/torque_boost_checker_asserts.sv ====
`timescale 1ns/100ps
module torque_boost_checker
  import torque_boost_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [6:0]  i_terminal,
  input wire logic        i_accel,
  input wire logic [10:0] i_freq_frac,
  input wire logic [9:0]  i_motor_current,
  input logic      [10:0] o_voltage_pct,
  input logic      [10:0] o_freq_out,
  input control_mode_t    o_control_mode,
  input logic             o_second_func_active,
  input logic      [7:0]  o_speed_gain_pct,
  input logic             o_overcurrent_alarm,
  input logic             o_accel_overcurrent_trip
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);

  a_voltage_cap: assert property (o_voltage_pct <= 11'h3e8)
    else $error("voltage above full scale");
  a_vector_no_boost: assert property ($past(o_control_mode) != mode_vf
    && o_control_mode != mode_vf && $past(i_motor_current) == 10'h000
    && $past(i_freq_frac) == 11'h000 |-> o_voltage_pct == 11'h000)
    else $error("boost applied under vector control");
  a_gain_adv_only: assert property ($past(o_control_mode) != mode_advanced
    && o_control_mode != mode_advanced |-> o_speed_gain_pct == 8'h00)
    else $error("speed gain outside advanced mode");
  a_freq_pass_through: assert property ($past(o_control_mode) != mode_advanced
    && o_control_mode != mode_advanced |-> o_freq_out == $past(i_freq_frac))
    else $error("frequency compensated outside advanced mode");
  a_alarm_cause: assert property ($rose(o_overcurrent_alarm)
    |-> $past(i_motor_current) > 10'h096)
    else $error("alarm without overcurrent");
  a_trip_after_alarm: assert property ($rose(o_accel_overcurrent_trip)
    |-> $past(o_overcurrent_alarm) && $past(i_accel))
    else $error("trip without alarm during acceleration");
  a_trip_mutes_alarm: assert property (o_accel_overcurrent_trip
    && $past(o_accel_overcurrent_trip) |-> !o_overcurrent_alarm)
    else $error("alarm stands beside trip");
  a_second_source: assert property ($rose(o_second_func_active)
    |-> $past(i_terminal, 3) != 7'h00)
    else $error("second function without terminal");
endmodule
bind torque_boost_control_select torque_boost_checker torque_boost_checker_i (.*);

// ==== testbench/terminal_panel.sv ====
`timescale 1ns/100ps
// Operator panel: holds the input terminal levels that the device samples.
module terminal_panel (
  input  wire logic       i_sys_clk,
  input  wire logic [6:0] i_level,
  output logic      [6:0] o_pins
);
  initial o_pins = 7'h00;
  always @(posedge i_sys_clk) o_pins <= i_level;
endmodule

// ==== testbench/torque_boost_control_select_test.sv ====
`timescale 1ns/100ps
`include "torque_boost_map.svh"
module torque_boost_control_select_test
  import torque_boost_pkg::*;
;
  logic          i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, i_accel = 1'b0;
  logic [9:0]    i_addr = 10'h000, i_motor_current = 10'h000;
  logic [15:0]   i_wdata = 16'h0000, o_rdata;
  logic [10:0]   i_freq_frac = 11'h000, o_voltage_pct, o_freq_out;
  logic [6:0]    level = 7'h00, i_terminal;
  logic [7:0]    o_speed_gain_pct;
  logic          o_second_func_active, o_oc, o_acc, o_mol, o_dol;
  control_mode_t o_control_mode;
  int            failures = 0, check_count = 0;

  always #5 i_sys_clk = ~i_sys_clk;

  terminal_panel terminal_panel_i (.i_sys_clk(i_sys_clk), .i_level(level), .o_pins(i_terminal));
  torque_boost_control_select torque_boost_control_select_i (
    .i_clk_en(1'b1), .o_overcurrent_alarm(o_oc), .o_accel_overcurrent_trip(o_acc),
    .o_motor_overload_trip(o_mol), .o_drive_overload_trip(o_dol), .*);

  task end_of_test;
    if (failures == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_m(input control_mode_t e);
    chk({14'h0000, o_control_mode}, {14'h0000, e});
  endtask

  task chk_f(input logic [3:0] e);
    chk({12'h000, o_dol, o_mol, o_acc, o_oc}, {12'h000, e});
  endtask

  task wr(input logic [9:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_addr <= a; i_wdata <= d; i_wr <= 1'b1;
    @(posedge i_sys_clk);
    i_wr <= 1'b0;
  endtask

  task rd_chk(input logic [9:0] a, input logic [15:0] exp);
    @(posedge i_sys_clk);
    i_addr <= a; i_rd <= 1'b1;
    @(posedge i_sys_clk);
    i_rd <= 1'b0;
    @(negedge i_sys_clk);
    chk(o_rdata, exp);
  endtask

  task settle;
    repeat (6) @(negedge i_sys_clk);
  endtask

  task drive(input logic [9:0] cur, input logic [10:0] f);
    @(posedge i_sys_clk);
    i_motor_current <= cur; i_freq_frac <= f;
    settle;
  endtask

  // Straight-line V/F value; frequencies above base stay on the full-voltage plateau.
  function logic [15:0] vf_exp(input int b, input int f);
    if (f > 1024) f = 1024;
    return 16'(b + ((1000 - b) * f) / 1024);
  endfunction

  task t_reset_values;
    rd_chk(`ADDR_PRIMARY_BOOST, 16'h001e);
    rd_chk(`ADDR_SECOND_BOOST, 16'h270f);
    rd_chk(`ADDR_APPLIED_MOTOR, 16'h0000);
    rd_chk(`ADDR_MOTOR_CAPACITY, 16'h270f);
    rd_chk(`ADDR_MOTOR_POLES, 16'h270f);
    rd_chk(`ADDR_SPEED_GAIN, 16'h270f);
    rd_chk(`ADDR_CTRL_METHOD, 16'h0014);
    rd_chk(10'h123, 16'h0000);
    chk_m(mode_vf);
  endtask

  task t_vf_curve;
    logic [10:0] fs [4];
    fs = '{11'h000, 11'h200, 11'h400, 11'h7ff};
    for (int k = 0; k < 4; k++) begin
      drive(10'h000, fs[k]);
      chk({5'h00, o_voltage_pct}, vf_exp(30, fs[k]));
    end
    wr(`ADDR_PRIMARY_BOOST, 16'h012c);
    wr(`ADDR_PRIMARY_BOOST, 16'h012d);
    drive(10'h000, 11'h000);
    chk({5'h00, o_voltage_pct}, 16'h012c);
    rd_chk(`ADDR_STATUS, 16'h0080);
    wr(`ADDR_FAULT_CLEAR, 16'h0080);
    wr(`ADDR_PRIMARY_BOOST, 16'h001e);
  endtask

  task t_second;
    wr(`ADDR_TERM_FIRST + 10'h002, `FUNC_SECOND);
    wr(`ADDR_SECOND_BOOST, 16'h0064);
    @(posedge i_sys_clk) level <= 7'h04;
    settle;
    chk({15'h0000, o_second_func_active}, 16'h0001);
    chk({5'h00, o_voltage_pct}, 16'h0064);
    rd_chk(`ADDR_STATUS, 16'h0004);
    wr(`ADDR_SECOND_BOOST, 16'h270f);
    settle;
    chk({5'h00, o_voltage_pct}, 16'h001e);
    @(posedge i_sys_clk) level <= 7'h08;
    settle;
    chk({15'h0000, o_second_func_active}, 16'h0000);
    @(posedge i_sys_clk) level <= 7'h00;
  endtask

  task t_motor_codes;
    logic [7:0] codes [18];
    codes = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0d, 8'h0e, 8'h0f,
              8'h10, 8'h17, 8'h18, 8'h28, 8'h2b, 8'h2c, 8'h32, 8'h35, 8'h36};
    for (int k = 0; k < 18; k++) begin
      wr(`ADDR_APPLIED_MOTOR, {8'h00, codes[k]});
      rd_chk(`ADDR_APPLIED_MOTOR, {8'h00, codes[k]});
    end
    wr(`ADDR_APPLIED_MOTOR, 16'h0002);
    rd_chk(`ADDR_APPLIED_MOTOR, 16'h0036);
    wr(`ADDR_PRIMARY_BOOST, 16'h001e);
    wr(`ADDR_APPLIED_MOTOR, 16'h0001);
    rd_chk(`ADDR_PRIMARY_BOOST, 16'h0014);
    wr(`ADDR_PRIMARY_BOOST, 16'h001e);
    wr(`ADDR_APPLIED_MOTOR, 16'h0000);
    rd_chk(`ADDR_PRIMARY_BOOST, 16'h001e);
    wr(`ADDR_FAULT_CLEAR, 16'h0080);
  endtask

  task t_mode;
    wr(`ADDR_MOTOR_CAPACITY, 16'h0096);
    settle;
    chk_m(mode_vf);
    wr(`ADDR_MOTOR_POLES, 16'h0004);
    drive(10'h000, 11'h000);
    chk_m(mode_advanced);
    chk({8'h00, o_speed_gain_pct}, 16'h0064);
    chk({5'h00, o_voltage_pct}, 16'h0000);
    drive(10'h050, 11'h064);
    chk({5'h00, o_voltage_pct}, 16'h006b);
    chk({5'h00, o_freq_out}, 16'h006b);
    wr(`ADDR_SPEED_GAIN, 16'h00c8);
    wr(`ADDR_SPEED_GAIN, 16'h00c9);
    settle;
    chk({5'h00, o_freq_out}, 16'h0073);
    rd_chk(`ADDR_SPEED_GAIN, 16'h00c8);
    wr(`ADDR_CTRL_METHOD, 16'h001e);
    wr(`ADDR_CTRL_METHOD, 16'h0019);
    wr(`ADDR_MOTOR_POLES, 16'h0003);
    wr(`ADDR_MOTOR_CAPACITY, 16'h0009);
    settle;
    chk_m(mode_general);
    chk({5'h00, o_freq_out}, 16'h0064);
    rd_chk(`ADDR_CTRL_METHOD, 16'h001e);
    rd_chk(`ADDR_MOTOR_POLES, 16'h0004);
    rd_chk(`ADDR_MOTOR_CAPACITY, 16'h0096);
    wr(`ADDR_MOTOR_POLES, 16'h270f);
    settle;
    chk_m(mode_vf);
    chk({5'h00, o_voltage_pct}, 16'h007c);
    drive(10'h000, 11'h000);
    wr(`ADDR_FAULT_CLEAR, 16'h0080);
  endtask

  task t_lock;
    wr(`ADDR_USER_GROUP, 16'h0001);
    wr(`ADDR_PRIMARY_BOOST, 16'h0032);
    rd_chk(`ADDR_PRIMARY_BOOST, 16'h001e);
    rd_chk(`ADDR_STATUS, 16'h0080);
    wr(`ADDR_USER_GROUP, 16'h0000);
    wr(`ADDR_PRIMARY_BOOST, 16'h0032);
    rd_chk(`ADDR_PRIMARY_BOOST, 16'h0032);
  endtask

  task t_faults;
    drive(10'h097, 11'h000);
    chk_f(4'h1);
    @(posedge i_sys_clk) i_accel <= 1'b1;
    repeat (2010) @(negedge i_sys_clk);
    chk_f(4'ha);
    repeat (1000) @(negedge i_sys_clk);
    chk_f(4'he);
    @(posedge i_sys_clk) i_accel <= 1'b0;
    drive(10'h000, 11'h000);
    wr(`ADDR_FAULT_CLEAR, 16'h0070);
    settle;
    chk_f(4'h0);
  endtask

  initial begin
    repeat (16) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    t_reset_values;
    t_vf_curve;
    t_second;
    t_motor_codes;
    t_mode;
    t_lock;
    t_faults;
    end_of_test;
  end

  initial begin
    repeat (50000) @(posedge i_sys_clk);
    failures++;
    end_of_test;
  end
endmodule
